// >>> logic/adcc_top.sv
// conversion control around a successive-approximation converter core
// assumes the core starts on core_start_o, steps on core_clk_en_o, answers with core_done_i
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - result resolution selectable as eight, ten or twelve bits
// - conversion clock from bus, bus halved, alternate or local async clock
// - selected clock divided by one, two, four or eight
// - reference choice between default reference pair and analog supply pair
// - compare adds result to ones-complement of compare value
// - compare modes: off, less than, greater or equal
// - software mode channel write starts; hardware mode waits for trigger
// - hardware trigger never masked, masked while results pending, or always
// - one queue of channels, one queue of results
// - active flag set while a conversion runs
// - flags for result queue empty and full
// - conversion-complete flag and readable converted value
// - pin-control bit isolates pin: no drive, no input, no pull-up
// - sixteen pin-control bits, bit zero for input zero
// - queue depth is setting plus one; zero turns queues off
// - queued mode: complete after all hits if and-compare, else any
// - one trigger may run many conversions; scan repeats first channel
// - channels zero to thirty-one, continuous mode, completion interrupt
module adcc_top #(
	parameter int FIFO_MAX = 8
) (
	input  wire logic                       sys_clk_i,
	input  wire logic                       nrst_i,
	input  wire logic [4:0]                 avs_address_i,
	input  wire logic                       avs_read_i,
	input  wire logic                       avs_write_i,
	input  wire logic [31:0]                avs_writedata_i,
	output logic      [31:0]                avs_readdata_o,
	output logic                            avs_waitrequest_o,
	input  wire logic                       hw_trig_i,
	input  wire logic                       alternate_clock_input_i,
	input  wire logic                       local_async_conversion_clock_i,
	input  wire logic                       core_done_i,
	input  wire logic [adcc_pkg::RES_W-1:0] core_result_i,
	output logic                            core_start_o,
	output logic [adcc_pkg::CHAN_W-1:0]     core_chan_o,
	output logic [1:0]                      core_res_o,
	output logic                            core_ref_supply_o,
	output logic                            core_clk_en_o,
	output logic [15:0]                     pin_isolate_o,
	output logic                            conv_irq_o
);
	localparam int AW = $clog2(FIFO_MAX);

	if (FIFO_MAX != 8)
		$error("FIFO_MAX must be 8 to serve the 3-bit depth setting");

	adcc_pkg::adcc_cfg_type   cfg;
	adcc_pkg::adcc_state_type state;
	logic [11:0]                 cmp_val;
	logic [adcc_pkg::CHAN_W-1:0] chan_mem [FIFO_MAX];
	logic [adcc_pkg::RES_W-1:0]  res_mem [FIFO_MAX];
	logic [AW:0]                 chan_cnt;
	logic [AW:0]                 res_cnt;
	logic [AW-1:0]               res_rd;
	logic [AW-1:0]               conv_idx;
	logic                        conv_done;
	logic                        any_hit;
	logic                        all_hit;
	logic                        run_all;
	logic                        half;
	logic [2:0]                  alt_sync;
	logic [2:0]                  asy_sync;
	logic [2:0]                  div_cnt;
	logic                        trig_d;

	function automatic logic [AW-1:0] wrap(input logic [AW:0] v);
		return v[AW-1:0];
	endfunction

	// queues off when depth setting is zero: single slot, results overwrite
	wire         fifo_en  = cfg.fifo_depth != 3'h0;
	wire [AW:0]  eff_dep  = {1'b0, cfg.fifo_depth} + 4'h1;
	wire         res_full = res_cnt == eff_dep;
	wire         res_emp  = res_cnt == '0;
	wire         acc      = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
	wire         wr_cfg   = acc & avs_write_i & (avs_address_i == adcc_pkg::OFF_CFG);
	wire         wr_chan  = acc & avs_write_i & (avs_address_i == adcc_pkg::OFF_CHAN);
	wire         rd_res   = acc & avs_read_i & (avs_address_i == adcc_pkg::OFF_RESULT);
	wire         chan_full = chan_cnt == eff_dep;

	// result masked to its width, right-justified
	logic [11:0] res_mask;
	always_comb
	begin
		unique case (cfg.res)
			adcc_pkg::ADCC_RES8:  res_mask = 12'h0ff;
			adcc_pkg::ADCC_RES10: res_mask = 12'h3ff;
			default:              res_mask = 12'hfff;
		endcase
	end
	wire [11:0] conv_val = core_result_i & res_mask;

	// compare: result + ~cv carries out when result > cv; all ones means equal
	wire [12:0] cmp_sum = {1'b0, conv_val} + {1'b0, ~cmp_val};
	wire        cmp_ge  = cmp_sum[12] | (cmp_sum[11:0] == 12'hfff);
	logic       cmp_hit;
	always_comb
	begin
		unique case (cfg.cmp_mode)
			adcc_pkg::ADCC_CMP_LESS: cmp_hit = ~cmp_ge;
			adcc_pkg::ADCC_CMP_GE:   cmp_hit = cmp_ge;
			default:                 cmp_hit = 1'b1;
		endcase
	end
	wire cmp_on = cfg.cmp_mode == adcc_pkg::ADCC_CMP_LESS || cfg.cmp_mode == adcc_pkg::ADCC_CMP_GE;

	// hardware trigger gating
	logic trig_ok;
	always_comb
	begin
		unique case (cfg.trig_mask)
			adcc_pkg::ADCC_MASK_NEVER: trig_ok = 1'b1;
			adcc_pkg::ADCC_MASK_AUTO:  trig_ok = res_emp;
			default:                   trig_ok = 1'b0;
		endcase
	end
	wire hw_edge  = hw_trig_i & ~trig_d;
	wire hw_start = cfg.hw_trig & hw_edge & trig_ok & (fifo_en ? chan_full : chan_cnt != '0);
	// software start: single mode on every channel write, queued mode once channels fill
	wire sw_start = ~cfg.hw_trig & wr_chan & (~fifo_en | (chan_cnt + 4'h1 == eff_dep));
	wire seq_end  = fifo_en ? (res_cnt + 4'h1 == eff_dep) : 1'b1;
	wire more     = fifo_en & ~seq_end & (run_all | cfg.scan);
	wire restart  = cfg.continuous & ~cfg.hw_trig & seq_end;

	// input sampling; conversion clock: pick a source edge, then divide; stepping enable to the core
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			trig_d   <= 1'b0;
			half     <= 1'b0;
			alt_sync <= 3'h0;
			asy_sync <= 3'h0;
		end
		else
		begin
			trig_d   <= hw_trig_i;
			half     <= ~half;
			alt_sync <= {alt_sync[1:0], alternate_clock_input_i};
			asy_sync <= {asy_sync[1:0], local_async_conversion_clock_i};
		end
	end

	logic src_tick;
	always_comb
	begin
		unique case (cfg.src)
			adcc_pkg::ADCC_SRC_BUS:  src_tick = 1'b1;
			adcc_pkg::ADCC_SRC_BUS2: src_tick = half;
			adcc_pkg::ADCC_SRC_ALT:  src_tick = alt_sync[1] & ~alt_sync[2];
			default:                 src_tick = asy_sync[1] & ~asy_sync[2];
		endcase
	end

	logic [2:0] div_top;
	always_comb
	begin
		unique case (cfg.div)
			adcc_pkg::ADCC_DIV1: div_top = 3'h0;
			adcc_pkg::ADCC_DIV2: div_top = 3'h1;
			adcc_pkg::ADCC_DIV4: div_top = 3'h3;
			default:             div_top = 3'h7;
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			div_cnt       <= 3'h0;
			core_clk_en_o <= 1'b0;
		end
		else
		begin
			core_clk_en_o <= 1'b0;
			if (src_tick)
			begin
				div_cnt <= (div_cnt >= div_top) ? 3'h0 : div_cnt + 3'h1;
				core_clk_en_o <= div_cnt >= div_top;
			end
		end
	end

	// registers written by software
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			cfg           <= adcc_pkg::CFG_RESET;
			cmp_val       <= adcc_pkg::CMP_RESET;
			pin_isolate_o <= adcc_pkg::PIN_RESET;
		end
		else if (acc & avs_write_i)
		begin
			if (avs_address_i == adcc_pkg::OFF_CFG)
				cfg <= {12'h000, avs_writedata_i[19:0]};
			if (avs_address_i == adcc_pkg::OFF_CMPVAL)
				cmp_val <= avs_writedata_i[11:0];
			// isolated pins: driver off, input and pull-up off, port reads zero
			if (avs_address_i == adcc_pkg::OFF_PINCTL)
				pin_isolate_o <= avs_writedata_i[15:0];
		end
	end

	// channel queue
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			chan_cnt <= '0;
		else if (wr_cfg)
			chan_cnt <= '0;
		else if (wr_chan && (!fifo_en || !chan_full))
		begin
			// single mode keeps one slot; a full queue ignores the write
			chan_mem[fifo_en ? wrap(chan_cnt) : '0] <= avs_writedata_i[4:0];
			chan_cnt                                <= fifo_en ? chan_cnt + 4'h1 : 4'h1;
		end
	end

	// sequencer and result queue
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			state        <= adcc_pkg::ADCC_IDLE;
			core_start_o <= 1'b0;
			core_chan_o  <= '0;
			conv_idx     <= '0;
			run_all      <= 1'b0;
			res_cnt      <= '0;
			res_rd       <= '0;
			conv_done    <= 1'b0;
			conv_irq_o   <= 1'b0;
			any_hit      <= 1'b0;
			all_hit      <= 1'b1;
		end
		else
		begin
			core_start_o <= 1'b0;
			conv_irq_o   <= conv_done & cfg.irq_en;
			if (rd_res & ~res_emp)
			begin
				res_rd  <= fifo_en ? res_rd + 1'b1 : '0;
				res_cnt <= res_cnt - 4'h1;
			end
			if (rd_res | wr_chan | wr_cfg)
				conv_done <= 1'b0;
			unique case (state)
				adcc_pkg::ADCC_IDLE:
					if (sw_start | hw_start)
					begin
						state        <= adcc_pkg::ADCC_CONV;
						core_start_o <= 1'b1;
						core_chan_o  <= (fifo_en | ~sw_start) ? chan_mem[0] : avs_writedata_i[4:0];
						conv_idx     <= '0;
						run_all      <= sw_start | cfg.hw_multi;
						any_hit      <= 1'b0;
						all_hit      <= 1'b1;
						if (!fifo_en || sw_start)
						begin
							res_cnt <= '0;
							res_rd  <= '0;
						end
					end
				adcc_pkg::ADCC_CONV:
					if (core_done_i)
					begin
						any_hit <= any_hit | cmp_hit;
						all_hit <= all_hit & cmp_hit;
						// single mode keeps only hits; queued mode keeps all
						if (fifo_en || cmp_hit)
						begin
							res_mem[fifo_en ? wrap(res_cnt) + res_rd : '0] <= conv_val;
							// a pop in the same cycle must not be lost
							res_cnt <= fifo_en ? res_cnt + 4'h1 - {3'h0, rd_res & ~res_emp} : 4'h1;
						end
						if (seq_end && (!cmp_on || (fifo_en ? (cfg.cmp_and ? all_hit & cmp_hit
							: any_hit | cmp_hit) : cmp_hit)))
							conv_done <= 1'b1;
						if (more || restart)
						begin
							core_start_o <= 1'b1;
							conv_idx     <= more & ~cfg.scan ? conv_idx + 1'b1 : '0;
							core_chan_o  <= chan_mem[more & ~cfg.scan ? conv_idx + 1'b1 : '0];
							if (restart && fifo_en)
							begin
								res_cnt <= '0;
								res_rd  <= '0;
							end
						end
						else
							state <= adcc_pkg::ADCC_IDLE;
					end
				default:
					state <= adcc_pkg::ADCC_IDLE;
			endcase
		end
	end

	assign core_res_o        = cfg.res;
	assign core_ref_supply_o = cfg.ref_supply;

	// bus slave: one wait cycle, read data loaded as waitrequest drops
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0000_0000;
		end
		else
		begin
			avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
			if (avs_read_i & avs_waitrequest_o)
			begin
				unique case (avs_address_i)
					adcc_pkg::OFF_CFG:    avs_readdata_o <= cfg;
					adcc_pkg::OFF_CHAN:   avs_readdata_o <= {27'h0, chan_mem[0]};
					adcc_pkg::OFF_STATUS: avs_readdata_o <= {28'h0, conv_done, res_full, res_emp,
						state == adcc_pkg::ADCC_CONV};
					adcc_pkg::OFF_RESULT: avs_readdata_o <= {20'h0, res_emp ? 12'h000 : res_mem[res_rd]};
					adcc_pkg::OFF_CMPVAL: avs_readdata_o <= {20'h0, cmp_val};
					adcc_pkg::OFF_PINCTL: avs_readdata_o <= {16'h0, pin_isolate_o};
					default:              avs_readdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

`default_nettype wire

// >>> logic/adcc_pkg.sv
// shared constants and types for the converter control block
// assumes a 32-bit avalon-mm register bus and one system clock
package adcc_pkg;
	localparam logic [4:0]  OFF_CFG    = 5'h00;
	localparam logic [4:0]  OFF_CHAN   = 5'h04;
	localparam logic [4:0]  OFF_STATUS = 5'h08;
	localparam logic [4:0]  OFF_RESULT = 5'h0c;
	localparam logic [4:0]  OFF_CMPVAL = 5'h10;
	localparam logic [4:0]  OFF_PINCTL = 5'h14;
	localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
	localparam logic [11:0] CMP_RESET  = 12'h000;
	localparam logic [15:0] PIN_RESET  = 16'h0000;
	localparam int          ST_ACTIVE  = 0;
	localparam int          ST_EMPTY   = 1;
	localparam int          ST_FULL    = 2;
	localparam int          ST_DONE    = 3;
	localparam int          RES_W      = 12;
	localparam int          CHAN_W     = 5;

	typedef enum logic [1:0] {ADCC_RES8, ADCC_RES10, ADCC_RES12, ADCC_RES_RSVD} adcc_res_type;
	typedef enum logic [1:0] {ADCC_SRC_BUS, ADCC_SRC_BUS2, ADCC_SRC_ALT, ADCC_SRC_ASYNC} adcc_src_type;
	typedef enum logic [1:0] {ADCC_DIV1, ADCC_DIV2, ADCC_DIV4, ADCC_DIV8} adcc_div_type;
	typedef enum logic [1:0] {ADCC_CMP_OFF, ADCC_CMP_LESS, ADCC_CMP_GE, ADCC_CMP_RSVD} adcc_cmp_type;
	typedef enum logic [1:0] {ADCC_MASK_NEVER, ADCC_MASK_AUTO, ADCC_MASK_ALWAYS, ADCC_MASK_RSVD} adcc_mask_type;
	typedef enum logic {ADCC_IDLE, ADCC_CONV} adcc_state_type;

	// configuration word, bit 0 at the bottom of the struct
	typedef struct packed {
		logic [11:0]   unused;
		logic          irq_en;
		logic          continuous;
		logic [2:0]    fifo_depth;
		logic          scan;
		logic          hw_multi;
		logic          cmp_and;
		adcc_cmp_type  cmp_mode;
		adcc_mask_type trig_mask;
		logic          hw_trig;
		logic          ref_supply;
		adcc_div_type  div;
		adcc_src_type  src;
		adcc_res_type  res;
	} adcc_cfg_type;
endpackage

// >>> tb/adcc_sva.sv
// port-level checker for the converter control block
// assumes one clock and a synchronous active-low reset; bound below
`timescale 1ns/1ns
`default_nettype none
module adcc_sva #(
	parameter int FIFO_MAX = 8
) (
	input wire logic                        sys_clk_i,
	input wire logic                        nrst_i,
	input wire logic [4:0]                  avs_address_i,
	input wire logic                        avs_read_i,
	input wire logic                        avs_write_i,
	input wire logic [31:0]                 avs_writedata_i,
	input wire logic [31:0]                 avs_readdata_o,
	input wire logic                        avs_waitrequest_o,
	input wire logic                        core_start_o,
	input wire logic [adcc_pkg::CHAN_W-1:0] core_chan_o,
	input wire logic [1:0]                  core_res_o,
	input wire logic                        core_ref_supply_o,
	input wire logic [15:0]                 pin_isolate_o,
	input wire logic                        conv_irq_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low longer than one cycle");
	a_wait_answer: assert property ((avs_read_i || avs_write_i) |-> ##[0:2] !avs_waitrequest_o)
		else $error("bus request not answered");
	a_unmapped_zero: assert property ((avs_read_i && !avs_waitrequest_o && avs_address_i > 5'h14) |-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_start_pulse: assert property (core_start_o |=> !core_start_o)
		else $error("start longer than one cycle");
	a_chan_hold: assert property ($changed(core_chan_o) |-> core_start_o)
		else $error("channel changed without start");
	a_res_cfg: assert property ((avs_write_i && !avs_waitrequest_o && avs_address_i == adcc_pkg::OFF_CFG) |=> core_res_o == $past(avs_writedata_i[1:0]))
		else $error("resolution not taken from config");
	a_ref_cfg: assert property ((avs_write_i && !avs_waitrequest_o && avs_address_i == adcc_pkg::OFF_CFG) |=> core_ref_supply_o == $past(avs_writedata_i[6]))
		else $error("reference not taken from config");
	a_pin_mask: assert property ((avs_write_i && !avs_waitrequest_o && avs_address_i == adcc_pkg::OFF_PINCTL) |=> pin_isolate_o == $past(avs_writedata_i[15:0]))
		else $error("pin mask not taken from write");
	c_start: cover property (core_start_o);
	c_irq: cover property (conv_irq_o);
	c_pin_top: cover property (pin_isolate_o == 16'h8000);
endmodule
bind adcc_top adcc_sva #(.FIFO_MAX(FIFO_MAX)) u_adcc_sva (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.core_start_o(core_start_o), .core_chan_o(core_chan_o), .core_res_o(core_res_o),
	.core_ref_supply_o(core_ref_supply_o), .pin_isolate_o(pin_isolate_o), .conv_irq_o(conv_irq_o));
`default_nettype wire

// >>> tb/adcc_core_model.sv
// behavioural converter core: answers each start delay_i plus one cycles after sampling it
// result pattern depends on channel; short resolutions right-justified
`timescale 1ns/1ns
`default_nettype none
module adcc_core_model (
	input  wire logic        sys_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        start_i,
	input  wire logic [4:0]  chan_i,
	input  wire logic [1:0]  res_i,
	input  wire logic [3:0]  delay_i,
	output logic             done_o,
	output logic      [11:0] result_o
);
	logic        busy;
	logic [3:0]  cnt;
	logic [11:0] val;
	always_ff @(posedge sys_clk_i)
	begin
		done_o <= 1'b0;
		// result line toggles when not valid so stale data never matches
		result_o <= ~result_o;
		if (!nrst_i)
		begin
			busy <= 1'b0;
			cnt <= 4'h0;
			result_o <= 12'h000;
		end
		else if (start_i && !busy)
		begin
			busy <= 1'b1;
			cnt <= delay_i;
			val <= {chan_i, 7'h2a} & (res_i == 2'd0 ? 12'h0ff : res_i == 2'd1 ? 12'h3ff : 12'hfff);
		end
		else if (busy && cnt == 4'h0)
		begin
			busy <= 1'b0;
			done_o <= 1'b1;
			result_o <= val;
		end
		else if (busy)
			cnt <= cnt - 4'h1;
	end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the converter control block
// assumes the core model on the far side and an avalon-mm master here
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
	$display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module tb_top;
	logic        sys_clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [4:0]  avs_address_i = 5'h00;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic        hw_trig_i = 1'b0;
	logic        alt_clk = 1'b0;
	logic        async_clk = 1'b0;
	logic [3:0]  delay = 4'ha;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        core_done_i;
	logic        core_start_o;
	logic        core_ref_supply_o;
	logic        core_clk_en_o;
	logic        conv_irq_o;
	logic [11:0] core_result_i;
	logic [4:0]  core_chan_o;
	logic [1:0]  core_res_o;
	logic [15:0] pin_isolate_o;
	int          err_total = 0;
	int          total_checks = 0;
	int          acnt = 0;
	adcc_top u_adcc_top (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .hw_trig_i(hw_trig_i),
		.alternate_clock_input_i(alt_clk), .local_async_conversion_clock_i(async_clk),
		.core_done_i(core_done_i), .core_result_i(core_result_i), .core_start_o(core_start_o),
		.core_chan_o(core_chan_o), .core_res_o(core_res_o), .core_ref_supply_o(core_ref_supply_o),
		.core_clk_en_o(core_clk_en_o), .pin_isolate_o(pin_isolate_o), .conv_irq_o(conv_irq_o));
	adcc_core_model u_adcc_core_model (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .start_i(core_start_o),
		.chan_i(core_chan_o), .res_i(core_res_o), .delay_i(delay), .done_o(core_done_i), .result_o(core_result_i));
	initial forever #50 sys_clk_i = ~sys_clk_i;
	// alternate clock period 8 cycles, local clock 12
	always @(posedge sys_clk_i)
	begin
		acnt <= acnt + 1;
		if (acnt % 4 == 3) alt_clk <= ~alt_clk;
		if (acnt % 6 == 5) async_clk <= ~async_clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do
		begin
			@(posedge sys_clk_i);
			n++;
		end
		while (avs_waitrequest_o !== 1'b0 && n < 40);
		`CHK("bus answer", 1'b1, n < 40)
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	function automatic logic [31:0] pat(input logic [4:0] c, input logic [1:0] r);
		pat = {20'h0, {c, 7'h2a} & (r == 2'd0 ? 12'h0ff : r == 2'd1 ? 12'h3ff : 12'hfff)};
	endfunction
	task automatic t_reset();
		logic [31:0] q;
		logic [4:0]  offs [4] = '{adcc_pkg::OFF_CFG, adcc_pkg::OFF_CMPVAL, adcc_pkg::OFF_PINCTL, 5'h18};
		foreach (offs[i])
		begin
			bus(1'b0, offs[i], 32'h0, q);
			`CHK("reset value", 32'h0, q)
		end
		bus(1'b0, adcc_pkg::OFF_STATUS, 32'h0, q);
		`CHK("reset status", 4'h2, q[3:0])
		$display("t_reset done");
	endtask
	task automatic t_clock();
		logic [31:0] q;
		int          per [4] = '{1, 2, 8, 12};
		int          n;
		int          e;
		for (int s = 0; s < 4; s++)
			for (int d = 0; d < 4; d++)
			begin
				wr(adcc_pkg::OFF_CFG, 32'(2 | (s << 2) | (d << 4)));
				bus(1'b0, adcc_pkg::OFF_CFG, 32'h0, q);
				`CHK("cfg readback", 32'(2 | (s << 2) | (d << 4)), q)
				repeat (8) @(posedge sys_clk_i);
				n = 0;
				repeat (64)
				begin
					@(posedge sys_clk_i);
					n += int'(core_clk_en_o === 1'b1);
				end
				e = 64 / (per[s] << d);
				`CHK("clk_en rate", 1'b1, n >= e - 1 && n <= e + 1)
			end
		$display("t_clock done");
	endtask
	task automatic conv(input logic [31:0] cfg, input logic [4:0] ch, input logic hit);
		logic [31:0] q;
		int          n;
		wr(adcc_pkg::OFF_CFG, cfg);
		wr(adcc_pkg::OFF_CHAN, {27'h0, ch});
		@(negedge sys_clk_i);
		`CHK("start chan", {1'b1, ch}, {core_start_o, core_chan_o})
		`CHK("res ref", {cfg[6], cfg[1:0]}, {core_ref_supply_o, core_res_o})
		bus(1'b0, adcc_pkg::OFF_STATUS, 32'h0, q);
		`CHK("active", 1'b1, q[adcc_pkg::ST_ACTIVE])
		n = 0;
		do @(posedge sys_clk_i); while (core_done_i !== 1'b1 && ++n < 40);
		bus(1'b0, adcc_pkg::OFF_STATUS, 32'h0, q);
		`CHK("flags", {hit, !hit, 1'b0}, {q[adcc_pkg::ST_DONE], q[adcc_pkg::ST_EMPTY], q[adcc_pkg::ST_ACTIVE]})
		bus(1'b0, adcc_pkg::OFF_RESULT, 32'h0, q);
		`CHK("result", hit ? pat(ch, cfg[1:0]) : 32'h0, q)
	endtask
	task automatic t_single();
		logic [31:0] cf [8] = '{32'h2, 32'h40, 32'h1, 32'h402, 32'h402, 32'h802, 32'h402, 32'h802};
		logic [11:0] cv [8] = '{12'h0, 12'h0, 12'h0, 12'h800, 12'h800, 12'h2aa, 12'h2aa, 12'h800};
		logic [4:0]  ch [8] = '{5'd5, 5'd31, 5'd31, 5'd5, 5'd31, 5'd5, 5'd5, 5'd5};
		logic [7:0]  hits = 8'h2f;
		foreach (cf[i])
		begin
			wr(adcc_pkg::OFF_CMPVAL, {20'h0, cv[i]});
			conv(cf[i], ch[i], hits[i]);
		end
		$display("t_single done");
	endtask
	task automatic hw_shot(input logic pulse, input logic exp);
		int n;
		if (pulse)
		begin
			@(posedge sys_clk_i) hw_trig_i <= 1'b1;
			@(posedge sys_clk_i) hw_trig_i <= 1'b0;
		end
		n = 0;
		repeat (24)
		begin
			@(posedge sys_clk_i);
			n += int'(core_start_o === 1'b1);
		end
		`CHK("hw start", exp, n == 1)
	endtask
	task automatic t_hw();
		logic [31:0] q;
		wr(adcc_pkg::OFF_CFG, 32'h082);
		wr(adcc_pkg::OFF_CHAN, 32'h3);
		hw_shot(1'b0, 1'b0);
		hw_shot(1'b1, 1'b1);
		bus(1'b0, adcc_pkg::OFF_RESULT, 32'h0, q);
		`CHK("hw result", pat(5'd3, 2'd2), q)
		wr(adcc_pkg::OFF_CFG, 32'h182);
		wr(adcc_pkg::OFF_CHAN, 32'h3);
		hw_shot(1'b1, 1'b1);
		wr(adcc_pkg::OFF_CHAN, 32'h3);
		hw_shot(1'b1, 1'b0);
		bus(1'b0, adcc_pkg::OFF_RESULT, 32'h0, q);
		`CHK("auto result", pat(5'd3, 2'd2), q)
		hw_shot(1'b1, 1'b1);
		bus(1'b0, adcc_pkg::OFF_RESULT, 32'h0, q);
		`CHK("auto rearm result", pat(5'd3, 2'd2), q)
		wr(adcc_pkg::OFF_CFG, 32'h282);
		wr(adcc_pkg::OFF_CHAN, 32'h3);
		hw_shot(1'b1, 1'b0);
		$display("t_hw done");
	endtask
	task automatic t_pins();
		logic [31:0] q;
		logic [15:0] m [3] = '{16'h0001, 16'h8000, 16'h7ffe};
		foreach (m[i])
		begin
			wr(adcc_pkg::OFF_PINCTL, {16'h0, m[i]});
			@(negedge sys_clk_i);
			`CHK("pin isolate", m[i], pin_isolate_o)
			bus(1'b0, adcc_pkg::OFF_PINCTL, 32'h0, q);
			`CHK("pin readback", {16'h0, m[i]}, q)
		end
		$display("t_pins done");
	endtask
	task automatic t_fifo();
		logic [31:0] q;
		int          k;
		int          nd;
		delay <= 4'h1;
		wr(adcc_pkg::OFF_CFG, 32'h88002);
		wr(adcc_pkg::OFF_CHAN, 32'h5);
		wr(adcc_pkg::OFF_CHAN, 32'h1f);
		k = 0;
		nd = 0;
		while (nd < 2 && k < 100)
		begin
			@(posedge sys_clk_i);
			k++;
			nd += int'(core_done_i === 1'b1);
		end
		bus(1'b0, adcc_pkg::OFF_STATUS, 32'h0, q);
		`CHK("queued flags", 4'hc, q[3:0])
		`CHK("irq", 1'b1, conv_irq_o)
		bus(1'b0, adcc_pkg::OFF_RESULT, 32'h0, q);
		`CHK("first result", pat(5'd5, 2'd2), q)
		bus(1'b0, adcc_pkg::OFF_RESULT, 32'h0, q);
		`CHK("second result", pat(5'd31, 2'd2), q)
		bus(1'b0, adcc_pkg::OFF_STATUS, 32'h0, q);
		`CHK("drained", 1'b1, q[adcc_pkg::ST_EMPTY])
		$display("t_fifo done");
	endtask
	task automatic wait_done(input int cnt);
		int k;
		k = 0;
		while (cnt > 0 && k < 100)
		begin
			@(posedge sys_clk_i);
			k++;
			cnt -= int'(core_done_i === 1'b1);
		end
	endtask
	task automatic t_scan();
		logic [31:0] q;
		// two-deep queue with scan: both results from the first channel
		wr(adcc_pkg::OFF_CFG, 32'h0c002);
		wr(adcc_pkg::OFF_CHAN, 32'h7);
		wr(adcc_pkg::OFF_CHAN, 32'h9);
		wait_done(2);
		repeat (2)
		begin
			bus(1'b0, adcc_pkg::OFF_RESULT, 32'h0, q);
			`CHK("scan result", pat(5'd7, 2'd2), q)
		end
		// only the second channel hits: or-compare completes, and-compare does not
		for (int a = 0; a < 2; a++)
		begin
			wr(adcc_pkg::OFF_CMPVAL, 32'h800);
			wr(adcc_pkg::OFF_CFG, 32'(32'h8802 | (a << 12)));
			wr(adcc_pkg::OFF_CHAN, 32'h5);
			wr(adcc_pkg::OFF_CHAN, 32'h1f);
			wait_done(2);
			bus(1'b0, adcc_pkg::OFF_STATUS, 32'h0, q);
			`CHK("and compare", !a, q[adcc_pkg::ST_DONE])
			repeat (2) bus(1'b0, adcc_pkg::OFF_RESULT, 32'h0, q);
		end
		$display("t_scan done");
	endtask
	initial
	begin
		repeat (30000) @(posedge sys_clk_i);
		err_total++;
		$display("[FAIL] watchdog exp done got timeout");
		wrap_up();
	end
	initial
	begin
		repeat (2) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		t_reset();
		t_clock();
		t_single();
		t_hw();
		t_pins();
		t_fifo();
		t_scan();
		wrap_up();
	end
endmodule
`default_nettype wire
